//--- hw/slfc_top.v
// Frame timing and control registers of the segment panel driver.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "slfc_defs.vh"

module slfc_top (
    input  wire        mclk_i,          // System clock, 25 MHz.
    input  wire        rst_i,           // Asynchronous reset, high.
    input  wire        psel_i,          // APB select.
    input  wire        penable_i,       // APB enable.
    input  wire        pwrite_i,        // APB direction, high writes.
    input  wire [7:0]  paddr_i,         // APB byte address.
    input  wire [31:0] pwdata_i,        // APB write data.
    output reg  [31:0] prdata_o,        // APB read data.
    output reg         pready_o,        // APB ready.
    output reg         pslverr_o,       // APB error, unmapped address.
    input  wire        timer_osc_input_i, // Timer oscillator pin.
    input  wire        ext_clk_i,       // External clock pin.
    input  wire        ext_clock_input_sel_i, // High picks external.
    input  wire        gie_i,           // Global interrupt enable.
    input  wire        irq_ack_i,       // Vector taken, one pulse.
    output reg         frame_irq_o,     // Start-of-frame request.
    output reg         frame_latch_o,   // Display data latch pulse.
    output reg  [3:0]  com_en_o,        // Common pins owned by display.
    output reg  [3:0]  com_sel_o,       // Active common, one-hot.
    output reg  [24:0] seg_en_o,        // Segment pins owned by display.
    output reg         blank_o,         // Drive all panel pins to ground.
    output reg         low_power_wave_o, // Low-power waveform in use.
    output reg         half_bias_o,     // One-half bias in use.
    output reg         static_bias_o,   // Static bias in use.
    output reg         prescaled_tick_o // Prescaled panel clock pulse.
);

    // Frame states, one-hot.
    localparam [2:0] ST_OFF   = 3'h1;
    localparam [2:0] ST_SHOW  = 3'h2;
    localparam [2:0] ST_BLANK = 3'h4;

    reg  [7:0]  ctrl_a_q;           // Control A storage, flag excluded.
    reg  [7:0]  ctrl_b_q;           // Control B storage.
    reg  [7:0]  frame_q;            // Frame rate storage.
    reg         flag_q;             // Frame interrupt flag.
    reg         osc_s1_q;           // Oscillator pin, first stage.
    reg         osc_s2_q;           // Oscillator pin, second stage.
    reg         ext_s1_q;           // External pin, first stage.
    reg         ext_s2_q;           // External pin, second stage.
    reg         async_prev_q;       // Previous selected async level.
    reg  [11:0] ps_cnt_q;           // Prescaler counter.
    reg  [2:0]  div_cnt_q;          // Clock divider counter.
    reg  [2:0]  slot_q;             // Prescaled tick within frame.
    reg         parity_q;           // Frame parity for low power.
    reg         lpw_q;              // Waveform latched for this frame.
    reg  [2:0]  state_q;            // Frame state.
    reg  [2:0]  state_d;            // Next frame state.
    reg         setup_q;            // Setup seen, access next.
    reg  [11:0] tap_mask;           // Selected prescaler mask.
    reg  [4:0]  seg_cnt;            // Selected segment count.
    reg  [2:0]  slot_last;          // Last tick of the frame.
    reg  [1:0]  com_idx;            // Active common index.
    reg  [3:0]  com_mask;           // Commons used by duty.
    reg  [7:0]  rd_val;             // Read mux result.
    reg         rd_hit;             // Address is mapped.

    // Register fields and bus strobes; all decodes stay combinational so
    // that a write lands on the very edge that ends the access phase.
    wire        en      = ctrl_a_q[`SLFC_A_EN];
    wire [1:0]  duty    = ctrl_b_q[`SLFC_B_DUTY_HI:`SLFC_B_DUTY_LO];
    wire [2:0]  seg_sel = ctrl_b_q[`SLFC_B_SEG_HI:`SLFC_B_SEG_LO];
    wire [2:0]  ps_sel  = frame_q[`SLFC_F_PS_HI:`SLFC_F_PS_LO];
    wire [2:0]  cd_sel  = frame_q[`SLFC_F_CD_HI:`SLFC_F_CD_LO];
    wire        async_lv = ext_clock_input_sel_i ? ext_s2_q : osc_s2_q;
    wire        wr_acc  = psel_i & penable_i & pwrite_i & setup_q;
    wire        wr_a    = wr_acc & (paddr_i == `SLFC_ADDR_CTRL_A);
    // The pin clock is seen only through the synchroniser, so it must run
    // well below half the system clock or its edges are lost.
    // System clock ticks always; the pin clock ticks on a rising edge.
    wire        lcd_tick = ctrl_b_q[`SLFC_B_CS] ?
                           (async_lv & ~async_prev_q) : 1'b1;
    wire        tap     = lcd_tick & ((ps_cnt_q & tap_mask) == tap_mask);
    wire        ps_tick = tap & (div_cnt_q == cd_sel);
    // A frame wraps on the prescaled tick that ends its last slot.
    wire        wrap    = ps_tick & (slot_q == slot_last);
    // A frame start runs the state machine; low power skips every other.
    wire        start   = (state_q == ST_OFF) ? en : wrap;
    wire        latch   = en & start &
                          ((state_q == ST_OFF) | ~lpw_q | parity_q);

    // Prescaler tap selection.
    always @* begin
        case (ps_sel)
            3'h0:    tap_mask = `SLFC_TAP_16;
            3'h1:    tap_mask = `SLFC_TAP_64;
            3'h2:    tap_mask = `SLFC_TAP_128;
            3'h3:    tap_mask = `SLFC_TAP_256;
            3'h4:    tap_mask = `SLFC_TAP_512;
            3'h5:    tap_mask = `SLFC_TAP_1024;
            3'h6:    tap_mask = `SLFC_TAP_2048;
            default: tap_mask = `SLFC_TAP_4096;
        endcase
    end

    // Segment driver count selection.
    always @* begin
        case (seg_sel)
            3'h0:    seg_cnt = `SLFC_SEG_13;
            3'h1:    seg_cnt = `SLFC_SEG_15;
            3'h2:    seg_cnt = `SLFC_SEG_17;
            3'h3:    seg_cnt = `SLFC_SEG_19;
            3'h4:    seg_cnt = `SLFC_SEG_21;
            3'h5:    seg_cnt = `SLFC_SEG_23;
            3'h6:    seg_cnt = `SLFC_SEG_24;
            default: seg_cnt = `SLFC_SEG_25;
        endcase
    end

    // Frame length and active common from duty and tick position.
    always @* begin
        slot_last = `SLFC_K8_LAST;
        com_idx   = 2'h0;
        com_mask  = 4'h1;
        case (duty)
            `SLFC_DUTY_STATIC: begin
                com_idx  = 2'h0;
                com_mask = 4'h1;
            end
            `SLFC_DUTY_HALF: begin
                com_idx  = {1'b0, slot_q[2]};
                com_mask = 4'h3;
            end
            `SLFC_DUTY_THIRD: begin
                slot_last = `SLFC_K6_LAST;
                com_idx   = slot_q[2:1];
                com_mask  = 4'h7;
            end
            default: begin
                com_idx  = slot_q[2:1];
                com_mask = 4'hF;
            end
        endcase
    end

    // Read mux; reserved bits come back as zero through the masks.
    always @* begin
        rd_hit = 1'b1;
        case (paddr_i)
            `SLFC_ADDR_CTRL_A: rd_val = (ctrl_a_q & `SLFC_MASK_A) |
                               ({7'h00, flag_q} << `SLFC_A_FLAG);
            `SLFC_ADDR_CTRL_B: rd_val = ctrl_b_q & `SLFC_MASK_B;
            `SLFC_ADDR_FRAME:  rd_val = frame_q & `SLFC_MASK_F;
            default: begin
                rd_val = `SLFC_RESET_VAL;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Next frame state, only moved at a frame start or a disable.
    always @* begin
        state_d = state_q;
        if (!en) begin
            state_d = ST_OFF;
        end else if (latch) begin
            // Blanking takes hold only once the running frame is done.
            case (state_q)
                ST_OFF, ST_SHOW, ST_BLANK:
                    state_d = ctrl_a_q[`SLFC_A_BLANK] ? ST_BLANK : ST_SHOW;
                default: state_d = ST_OFF;
            endcase
        end
    end

    // APB slave: one wait-free access phase, answered from flops.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            setup_q   <= 1'b0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            // A write needs a setup seen first, so a penable held high
            // across transfers cannot commit the same word twice.
            setup_q   <= psel_i & ~penable_i;
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~rd_hit;
            if (psel_i & ~penable_i & ~pwrite_i) begin
                prdata_o <= {24'h00_0000, rd_val};
            end
        end
    end

    // Register writes; the flag store is separate below.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_a_q <= `SLFC_RESET_VAL;
            ctrl_b_q <= `SLFC_RESET_VAL;
            frame_q  <= `SLFC_RESET_VAL;
        end else if (wr_acc) begin
            if (wr_a) begin
                ctrl_a_q <= pwdata_i[7:0] & `SLFC_MASK_A &
                            ~(8'h01 << `SLFC_A_FLAG);
            end
            if (paddr_i == `SLFC_ADDR_CTRL_B) begin
                ctrl_b_q <= pwdata_i[7:0] & `SLFC_MASK_B;
            end
            if (paddr_i == `SLFC_ADDR_FRAME) begin
                frame_q <= pwdata_i[7:0] & `SLFC_MASK_F;
            end
        end
    end

    // Frame flag: a data latch in the same cycle beats any clear.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (latch) begin
            flag_q <= 1'b1;
        end else if (irq_ack_i |
                     (wr_a & pwdata_i[`SLFC_A_FLAG])) begin
            // A read-modify-write that keeps a set flag clears it.
            flag_q <= 1'b0;
        end
    end

    // Pin clock synchronisers; only the second stages are used.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_s1_q     <= 1'b0;
            osc_s2_q     <= 1'b0;
            ext_s1_q     <= 1'b0;
            ext_s2_q     <= 1'b0;
            async_prev_q <= 1'b0;
        end else begin
            osc_s1_q     <= timer_osc_input_i;
            osc_s2_q     <= osc_s1_q;
            ext_s1_q     <= ext_clk_i;
            ext_s2_q     <= ext_s1_q;
            async_prev_q <= async_lv;
        end
    end

    // Prescaler, divider and frame slot counters; held at zero when off.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ps_cnt_q  <= 12'h000;
            div_cnt_q <= 3'h0;
            slot_q    <= 3'h0;
        end else if (!en) begin
            // Cleared counters make the first frame after enable a full one.
            ps_cnt_q  <= 12'h000;
            div_cnt_q <= 3'h0;
            slot_q    <= 3'h0;
        end else begin
            if (lcd_tick) begin
                ps_cnt_q <= ps_cnt_q + 12'h001;
            end
            if (tap) begin
                // Divide by code plus one.
                div_cnt_q <= ps_tick ? 3'h0 : div_cnt_q + 3'h1;
            end
            if (ps_tick) begin
                slot_q <= wrap ? 3'h0 : slot_q + 3'h1;
            end
        end
    end

    // Frame state, parity and waveform latched at each data latch.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q  <= ST_OFF;
            parity_q <= 1'b0;
            lpw_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            if (!en) begin
                parity_q <= 1'b0;
            end else if (start && state_q != ST_OFF) begin
                parity_q <= ~parity_q;
            end
            if (latch) begin
                lpw_q    <= ctrl_a_q[`SLFC_A_LPW];
                parity_q <= 1'b0;
            end
        end
    end

    // Pin control outputs, all registered; disable frees every pin.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_irq_o      <= 1'b0;
            frame_latch_o    <= 1'b0;
            com_en_o         <= 4'h0;
            com_sel_o        <= 4'h0;
            seg_en_o         <= 25'h000_0000;
            blank_o          <= 1'b0;
            low_power_wave_o <= 1'b0;
            half_bias_o      <= 1'b0;
            static_bias_o    <= 1'b0;
            prescaled_tick_o <= 1'b0;
        end else begin
            frame_irq_o <= flag_q & ctrl_a_q[`SLFC_A_IE] & gie_i;
            frame_latch_o <= latch;
            prescaled_tick_o <= ps_tick;
            if (state_q == ST_OFF || !en) begin
                com_en_o  <= 4'h0;
                com_sel_o <= 4'h0;
                seg_en_o  <= 25'h000_0000;
                blank_o   <= 1'b0;
            end else begin
                com_en_o  <= com_mask;
                com_sel_o <= (4'h1 << com_idx) & com_mask;
                // Only the first count segments are owned by the driver.
                seg_en_o  <= 25'h1FF_FFFF >>
                             (`SLFC_SEG_25 - seg_cnt);
                blank_o   <= (state_q == ST_BLANK);
            end
            low_power_wave_o <= lpw_q;
            // Bias follows the registers at once; the waveform and blanking wait for a data latch.
            half_bias_o   <= ctrl_b_q[`SLFC_B_HALF] &
                             (duty != `SLFC_DUTY_STATIC);
            static_bias_o <= (duty == `SLFC_DUTY_STATIC);
        end
    end

endmodule // slfc_top

//--- hw/slfc_defs.vh
// Constants for the segment panel frame control block.
`ifndef SLFC_DEFS_VH
`define SLFC_DEFS_VH
// Register byte addresses.
`define SLFC_ADDR_CTRL_A   8'h00
`define SLFC_ADDR_CTRL_B   8'h04
`define SLFC_ADDR_FRAME    8'h08
// Control A field positions.
`define SLFC_A_EN          7
`define SLFC_A_LPW         6
`define SLFC_A_FLAG        4
`define SLFC_A_IE          3
`define SLFC_A_BLANK       0
// Control B field positions.
`define SLFC_B_CS          7
`define SLFC_B_HALF        6
`define SLFC_B_DUTY_HI     5
`define SLFC_B_DUTY_LO     4
`define SLFC_B_SEG_HI      2
`define SLFC_B_SEG_LO      0
// Frame rate field positions.
`define SLFC_F_PS_HI       6
`define SLFC_F_PS_LO       4
`define SLFC_F_CD_HI       2
`define SLFC_F_CD_LO       0
// Writable bit masks; the rest read as zero.
`define SLFC_MASK_A        8'hD9
`define SLFC_MASK_B        8'hF7
`define SLFC_MASK_F        8'h77
`define SLFC_RESET_VAL     8'h00
// Duty codes.
`define SLFC_DUTY_STATIC   2'h0
`define SLFC_DUTY_HALF     2'h1
`define SLFC_DUTY_THIRD    2'h2
`define SLFC_DUTY_QUARTER  2'h3
// Prescaled ticks per frame, the duty constant minus one.
`define SLFC_K8_LAST       3'h7
`define SLFC_K6_LAST       3'h5
// Prescaler tap masks, divider minus one.
`define SLFC_TAP_16        12'h00F
`define SLFC_TAP_64        12'h03F
`define SLFC_TAP_128       12'h07F
`define SLFC_TAP_256       12'h0FF
`define SLFC_TAP_512       12'h1FF
`define SLFC_TAP_1024      12'h3FF
`define SLFC_TAP_2048      12'h7FF
`define SLFC_TAP_4096      12'hFFF
// Segment driver counts.
`define SLFC_SEG_13        5'h0D
`define SLFC_SEG_15        5'h0F
`define SLFC_SEG_17        5'h11
`define SLFC_SEG_19        5'h13
`define SLFC_SEG_21        5'h15
`define SLFC_SEG_23        5'h17
`define SLFC_SEG_24        5'h18
`define SLFC_SEG_25        5'h19
`endif

//--- test/slfc_top_asserts.sv
// Concurrent checks on the ports of the segment panel frame control.
`timescale 1ns/1ps
module slfc_top_asserts (
    input wire        mclk_i,          // System clock.
    input wire        rst_i,           // Asynchronous reset, high.
    input wire        gie_i,           // Global interrupt enable.
    input wire        frame_irq_o,     // Start-of-frame request.
    input wire        frame_latch_o,   // Data latch pulse.
    input wire [3:0]  com_en_o,        // Commons owned by display.
    input wire [3:0]  com_sel_o,       // Active common.
    input wire [24:0] seg_en_o,        // Segments owned by display.
    input wire        half_bias_o,     // Half bias in use.
    input wire        static_bias_o,   // Static bias in use.
    input wire        prescaled_tick_o // Prescaled clock pulse.
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Shortest tap is 16 clocks and a frame is six ticks or more.
    sequence s_no_tick; !prescaled_tick_o [*8]; endsequence
    sequence s_no_latch; !frame_latch_o [*8]; endsequence
    AST_IRQ_GATED: assert property (
        frame_irq_o |-> $past(gie_i))
        else $error("frame request without global enable");
    AST_SEG_CONTIG: assert property (
        ((seg_en_o + 25'h1) & seg_en_o) == 0 &&
        (seg_en_o == 0 || &seg_en_o[12:0]))
        else $error("segment ownership not a run from zero");
    AST_COM_ONEHOT: assert property (
        $onehot0(com_sel_o) && (com_sel_o & ~com_en_o) == 4'h0)
        else $error("active common not one-hot or not owned");
    AST_COM_CONTIG: assert property (
        com_en_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
        else $error("common ownership not a run from zero");
    AST_TICK_SPACE: assert property (
        prescaled_tick_o |=> s_no_tick)
        else $error("prescaled ticks too close");
    AST_LATCH_SPACE: assert property (
        frame_latch_o |=> s_no_latch)
        else $error("frame latches too close");
    AST_STATIC: assert property (
        com_en_o != 4'h0 |-> static_bias_o == (com_en_o == 4'h1))
        else $error("static bias does not follow duty");
    AST_HALF: assert property (half_bias_o |-> !static_bias_o)
        else $error("half bias with static duty");
    AST_OFF: assert property (
        (seg_en_o == 0) == (com_en_o == 0))
        else $error("segments and commons released apart");
endmodule // slfc_top_asserts

bind slfc_top slfc_top_asserts u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .gie_i(gie_i),
    .frame_irq_o(frame_irq_o), .frame_latch_o(frame_latch_o),
    .com_en_o(com_en_o), .com_sel_o(com_sel_o), .seg_en_o(seg_en_o),
    .half_bias_o(half_bias_o), .static_bias_o(static_bias_o),
    .prescaled_tick_o(prescaled_tick_o));

//--- test/slfc_panel_model.sv
// Passive segment glass model that records the commons scanned per frame.
`timescale 1ns/1ps
module slfc_panel_model (
    input  wire       mclk_i,    // System clock.
    input  wire       rst_i,     // Asynchronous reset, high.
    input  wire       latch_i,   // Frame boundary pulse.
    input  wire [3:0] com_sel_i, // Active common.
    input  wire [3:0] com_en_i,  // Commons driven by the display.
    input  wire       blank_i,   // Panel pins grounded.
    output reg  [3:0] seen_o     // Commons scanned in the last frame.
);
    reg [3:0] acc_q; // Commons scanned so far in this frame.
    // Glass only sees commons that are driven; grounded pins show nothing.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q  <= 4'h0;
            seen_o <= 4'h0;
        end else if (latch_i) begin
            seen_o <= blank_i ? 4'h0 : (acc_q | (com_sel_i & com_en_i));
            acc_q  <= 4'h0;
        end else if (!blank_i) begin
            acc_q <= acc_q | (com_sel_i & com_en_i);
        end
    end
endmodule // slfc_panel_model

//--- test/segment_lcd_frame_control_bench.sv
// Self-checking bench for the segment panel frame control block.
`timescale 1ns/1ps
module segment_lcd_frame_control_bench;
    reg mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    reg [7:0]  paddr_i = 0;  // Bus address.
    reg [31:0] pwdata_i = 0; // Bus write data.
    reg timer_osc_input_i = 0, ext_clk_i = 0, ext_clock_input_sel_i = 0;
    reg gie_i = 1, irq_ack_i = 0;
    reg [2:0] dv_q = 0;      // Makes the two slow pin clocks.
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, frame_irq_o, frame_latch_o, blank_o;
    wire low_power_wave_o, half_bias_o, static_bias_o, prescaled_tick_o;
    wire [3:0] com_en_o, com_sel_o, seen;
    wire [24:0] seg_en_o;
    integer n_tests = 0, n_mismatch = 0, i, c, ps, cd, du, h;
    reg [31:0] rv;           // Last read data.
    reg err;                 // Last error response.
    slfc_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .timer_osc_input_i(timer_osc_input_i),
        .ext_clk_i(ext_clk_i), .ext_clock_input_sel_i(ext_clock_input_sel_i),
        .gie_i(gie_i), .irq_ack_i(irq_ack_i), .frame_irq_o(frame_irq_o),
        .frame_latch_o(frame_latch_o), .com_en_o(com_en_o),
        .com_sel_o(com_sel_o), .seg_en_o(seg_en_o), .blank_o(blank_o),
        .low_power_wave_o(low_power_wave_o), .half_bias_o(half_bias_o),
        .static_bias_o(static_bias_o), .prescaled_tick_o(prescaled_tick_o));
    slfc_panel_model u_panel (.mclk_i(mclk_i), .rst_i(rst_i),
        .latch_i(frame_latch_o), .com_sel_i(com_sel_o), .com_en_i(com_en_o),
        .blank_i(blank_o), .seen_o(seen));
    always #20 mclk_i = ~mclk_i;
    // Pin clocks: oscillator every 8 clocks, external every 4.
    always @(posedge mclk_i) begin
        dv_q <= dv_q + 3'h1;
        timer_osc_input_i <= dv_q[2];
        ext_clk_i <= dv_q[1];
    end
    function integer nseg(input integer k);
        nseg = (k < 6) ? 13 + 2 * k : 18 + k;
    endfunction
    // Frame length in clocks: duty constant, tap and divide factor.
    function integer nframe(input integer p, input integer d,
                            input integer u);
        nframe = (u == 2 ? 6 : 8) * (16 << 2 * p) * (d + 1);
    endfunction
    task close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task check(input [31:0] s, input [31:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: saw %h, want %h", $time, s, e);
        end
    endtask
    // One bus transfer; read data and error are taken at the ready edge.
    task apb(input [7:0] a, input w, input [7:0] d);
        integer k;
        psel_i <= 1; penable_i <= 0; pwrite_i <= w;
        paddr_i <= a; pwdata_i <= {24'h0, d};
        @(posedge mclk_i);
        penable_i <= 1;
        k = 0;
        do begin @(posedge mclk_i); k = k + 1; end
        while (pready_o !== 1'b1 && k < 20);
        if (k >= 20) begin n_mismatch = n_mismatch + 1; close_out; end
        rv = prdata_o; err = pslverr_o;
        psel_i <= 0; penable_i <= 0;
        // One idle edge keeps two calls from driving psel twice in a step.
        @(posedge mclk_i);
    endtask
    // Cycles until the next tick (t=1) or latch (t=0), bounded.
    task wait_ev(input integer t, output integer n);
        n = 0;
        do begin @(posedge mclk_i); n = n + 1; end
        while ((t ? prescaled_tick_o : frame_latch_o) !== 1'b1 && n < 20000);
        if (n >= 20000) begin n_mismatch = n_mismatch + 1; close_out; end
    endtask
    initial begin
        void'($urandom(51697));
        repeat (3) @(posedge mclk_i);
        rst_i <= 0;
        @(posedge mclk_i);
        // Reset values, writable masks and an unmapped address.
        for (i = 0; i < 3; i++) begin
            apb({i[5:0], 2'b00}, 0, 0); check(rv, 0);
        end
        apb(8'h00, 1, 8'h6F); apb(8'h00, 0, 0); check(rv, 32'h49);
        apb(8'h04, 1, 8'hFF); apb(8'h04, 0, 0); check(rv, 32'hF7);
        apb(8'h08, 1, 8'hFF); apb(8'h08, 0, 0); check(rv, 32'h77);
        apb(8'h0C, 0, 0); check({23'h0, rv[7:0], err}, 32'h1);
        apb(8'h08, 1, 0);
        $display("test done: registers");
        // Every segment count and duty, bias drawn at random.
        for (i = 0; i < 8; i++) begin
            h = $urandom % 2;
            apb(8'h04, 1, {1'b0, h[0], i[1:0], 1'b0, i[2:0]});
            apb(8'h00, 1, 8'h80);
            repeat (4) @(posedge mclk_i);
            check(seg_en_o, (32'h1 << nseg(i)) - 1);
            check(com_en_o, (4'h2 << (i % 4)) - 1);
            check(static_bias_o, i % 4 == 0);
            check(half_bias_o, h && i % 4 != 0);
        end
        $display("test done: duty and segments");
        // Random frame rates: tick and frame periods, commons scanned.
        for (i = 0; i < 3; i++) begin
            ps = $urandom % 2; cd = $urandom % 8; du = $urandom % 4;
            apb(8'h08, 1, {1'b0, ps[2:0], 1'b0, cd[2:0]});
            apb(8'h04, 1, {2'b00, du[1:0], 4'h7});
            wait_ev(0, c); wait_ev(1, c); wait_ev(1, c);
            check(c, (16 << 2 * ps) * (cd + 1));
            wait_ev(0, c); wait_ev(0, c);
            check(c, nframe(ps, cd, du));
            @(posedge mclk_i);
            check(seen, (4'h2 << du) - 1);
            apb(8'h00, 0, 0); check(rv[4], 1);
        end
        $display("test done: frame rate");
        // Request gating and both ways of clearing the flag.
        apb(8'h08, 1, 0); apb(8'h04, 1, 8'h30); apb(8'h00, 1, 8'h98);
        wait_ev(0, c); repeat (2) @(posedge mclk_i);
        check(frame_irq_o, 1);
        gie_i <= 0; repeat (2) @(posedge mclk_i);
        check(frame_irq_o, 0);
        gie_i <= 1; apb(8'h00, 0, 0); check(rv, 32'h98);
        // Writing back the word just read clears the pending request.
        apb(8'h00, 1, rv[7:0]); repeat (2) @(posedge mclk_i);
        check(frame_irq_o, 0);
        apb(8'h00, 0, 0); check(rv[4], 0);
        wait_ev(0, c); irq_ack_i <= 1; @(posedge mclk_i);
        irq_ack_i <= 0; repeat (2) @(posedge mclk_i);
        check(frame_irq_o, 0);
        $display("test done: frame request");
        // Low-power waveform waits for the frame and halves latches.
        wait_ev(0, c); apb(8'h00, 1, 8'hC0);
        check(low_power_wave_o, 0);
        wait_ev(0, c); @(posedge mclk_i);
        check(low_power_wave_o, 1);
        wait_ev(0, c); wait_ev(0, c);
        check(c, 2 * nframe(0, 0, 3));
        // Blanking waits for the frame end; disable releases at once.
        apb(8'h00, 1, 8'h81); check(blank_o, 0);
        wait_ev(0, c); repeat (2) @(posedge mclk_i);
        check(blank_o, 1);
        wait_ev(0, c); @(posedge mclk_i);
        check(seen, 0);
        apb(8'h00, 1, 0); repeat (2) @(posedge mclk_i);
        check({seg_en_o, com_en_o, com_sel_o}, 0);
        $display("test done: waveform, blank, disable");
        // Asynchronous source: pin clock picked by the external select.
        apb(8'h04, 1, 8'hB0); apb(8'h00, 1, 8'h80);
        for (i = 0; i < 2; i++) begin
            ext_clock_input_sel_i <= i[0];
            wait_ev(1, c); wait_ev(1, c); wait_ev(1, c);
            check(c, i ? 64 : 128);
        end
        $display("test done: clock source");
        close_out;
    end
endmodule // segment_lcd_frame_control_bench
